//--- src/rsi_pkg.sv
// Purpose: Shared constants and types of the reset state initializer.
// Assumes: 8-bit register bus with 9-bit addresses and a 13-bit program counter.
// Notes: Every register offset lives here; the status reset word and the interrupt flag and enable fields are set in rsi_core.
package rsi_pkg;

  // Bus, data and program counter widths.
  localparam int AW = 9;
  localparam int DW = 8;
  localparam int PCW = 13;
  // Number of interrupt sources.
  localparam int NSRC = 12;

  // Register offsets.
  localparam logic [AW-1:0] A_STATUS = 9'h003;
  localparam logic [AW-1:0] A_IRQ_CONTROL_REG = 9'h00B;
  localparam logic [AW-1:0] A_PERIPH_IRQ_FLAGS_1 = 9'h00C;
  localparam logic [AW-1:0] A_PERIPH_IRQ_FLAGS_2 = 9'h00D;
  localparam logic [AW-1:0] A_OPTION = 9'h081;
  localparam logic [AW-1:0] A_TRISA = 9'h085;
  localparam logic [AW-1:0] A_PIE1 = 9'h08C;
  localparam logic [AW-1:0] A_PIE2 = 9'h08D;
  localparam logic [AW-1:0] A_RESET_CAUSE_FLAGS = 9'h08E;
  localparam logic [AW-1:0] A_EVT = 9'h1F0;
  localparam logic [AW-1:0] A_EMASK = 9'h1F1;

  // Program counter targets.
  localparam logic [PCW-1:0] PC_RESET = 13'h0000;
  localparam logic [PCW-1:0] PC_VECTOR = 13'h0004;

  // Field positions in the core status word and control registers.
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam int PF_POR = 1;
  localparam int PF_BOR = 0;
  localparam int IC_GIE = 7;
  localparam int IC_PEIE = 6;

  // Reset values of control registers.
  localparam logic [DW-1:0] RST_ONES = 8'hFF;
  localparam logic [DW-1:0] RST_ZERO = 8'h00;
  // Reset-cause flag values after power-on and after brown-out.
  localparam logic [1:0] RESET_CAUSE_FLAGS_POR = 2'h0;
  localparam logic [1:0] RESET_CAUSE_FLAGS_BOR = 2'h2;

  // Event status bit positions.
  localparam int EVW = 7;
  localparam int EV_POR = 0;
  localparam int EV_BOR = 1;
  localparam int EV_PIN = 2;
  localparam int EV_WDR = 3;
  localparam int EV_WDW = 4;
  localparam int EV_IWK = 5;
  localparam int EV_VEC = 6;

  // Operating mode of the sequencer.
  typedef enum logic [1:0] {RSI_RUN, RSI_SLEEP, RSI_WAKE} rsi_mode_t;

  // Register bus request from software.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } rsi_bus_t;

  // Complete state of the core module.
  typedef struct packed {
    rsi_mode_t mode;
    logic gw;
    logic pin_q;
    logic pc_ld;
    logic [PCW-1:0] pc;
    logic [DW-1:0] status;
    logic [1:0] reset_cause_flags;
    logic [DW-1:0] irq_control_reg;
    logic [DW-1:0] periph_irq_flags_1;
    logic [DW-1:0] pie1;
    logic periph_irq_flags_2;
    logic pie2;
    logic [DW-1:0] option;
    logic [DW-1:0] trisa;
    logic [EVW-1:0] evt;
    logic [EVW-1:0] mask;
    logic [DW-1:0] rdata;
  } rsi_state_t;

  // State of the pin synchroniser.
  typedef struct packed {
    logic [2:0] ff;
    logic lvl;
  } rsi_sync_t;

endpackage : rsi_pkg

//--- src/rsi_pin_sync.sv
// Purpose: Three-stage synchroniser for the external reset pin.
// Assumes: The pin idles high and is asynchronous to clk_in.
// Notes: The level changes only once the second and third stages agree.
module rsi_pin_sync import rsi_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic pin_in,
  output logic level_out
);

  // Registered state and its next value.
  rsi_sync_t s_q;
  rsi_sync_t s_d;

  // Shift the pin in; only stages two and three feed the filter.
  always_comb begin
    s_d = s_q;
    s_d.ff = {s_q.ff[1:0], pin_in};
    if (s_q.ff[1] == s_q.ff[2]) begin
      s_d.lvl = s_q.ff[2];
    end
  end

  // Synchronous reset to the released level.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_q <= '{ff: 3'h7, lvl: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // The filtered level comes straight from a flip-flop.
  assign level_out = s_q.lvl;

endmodule // rsi_pin_sync

//--- src/rsi_core.sv
// Purpose: Applies program counter, status and reset-cause values per reset or wake cause.
// Assumes: nrst_in low is the power-on reset; the reset pin is an asynchronous level and other causes are pulses on clk_in.
// Notes: Register reads return data one cycle after the read strobe.
//
// Local design decision: the address-and-strobe port.
module rsi_core import rsi_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic bor_in,
  input wire logic ext_rst_pin_n_in,
  input wire logic wdt_timeout_in,
  input wire logic sleep_in,
  input wire logic instr_done_in,
  input wire logic [PCW-1:0] pc_in,
  input wire logic [NSRC-1:0] irq_src_in,
  input wire rsi_bus_t bus_in,
  output logic [DW-1:0] rdata_out,
  output logic pc_load_out,
  output logic [PCW-1:0] pc_value_out,
  output logic [DW-1:0] status_out,
  output logic [1:0] reset_cause_out,
  output logic [DW-1:0] option_out,
  output logic [DW-1:0] trisa_out,
  output logic asleep_out,
  output logic irq_out
);

  // State after power-on: the low status bits are don't-care, held at zero.
  // unknown bits zeroed
  localparam rsi_state_t S_POR = '{
    mode: RSI_RUN, gw: 1'b0, pin_q: 1'b1, pc_ld: 1'b1, pc: PC_RESET,
    status: 8'h18, reset_cause_flags: RESET_CAUSE_FLAGS_POR, irq_control_reg: RST_ZERO, periph_irq_flags_1: RST_ZERO,
    pie1: RST_ZERO, periph_irq_flags_2: 1'b0, pie2: 1'b0, option: RST_ONES,
    trisa: RST_ONES, evt: 7'h01, mask: 7'h00, rdata: RST_ZERO};

  // Registered state and its next value.
  rsi_state_t s_q;
  rsi_state_t s_d;
  // Filtered external reset pin level.
  logic pin_n_sync;
  // Decoded cause events for this cycle.
  logic pin_fall;
  logic ev_bor;
  logic ev_pin;
  logic ev_wdt;
  logic pend;
  logic ev_wake;
  logic ev_vec;
  logic wake_done;

  // True when the bus addresses the given register.
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] r);
    return a == r;
  endfunction

  // Control registers return to their defined values on any full reset.
  function automatic rsi_state_t ctrl_reset(input rsi_state_t s);
    rsi_state_t r;
    r = s;
    r.option = RST_ONES;
    r.trisa = RST_ONES;
    r.pie1 = RST_ZERO;
    r.pie2 = 1'b0;
    r.irq_control_reg = {7'h00, s.irq_control_reg[0]};
    r.periph_irq_flags_1 = RST_ZERO;
    r.periph_irq_flags_2 = 1'b0;
    r.pc = PC_RESET;
    r.pc_ld = 1'b1;
    r.mode = RSI_RUN;
    return r;
  endfunction

  // Read multiplexer; unmapped and unimplemented bits read as zero.
  function automatic logic [DW-1:0] rd_mux(input rsi_state_t s, input logic [AW-1:0] a);
    logic [DW-1:0] v;
    v = RST_ZERO;
    if (hit(a, A_STATUS)) v = s.status;
    if (hit(a, A_IRQ_CONTROL_REG)) v = s.irq_control_reg;
    if (hit(a, A_PERIPH_IRQ_FLAGS_1)) v = s.periph_irq_flags_1;
    if (hit(a, A_PERIPH_IRQ_FLAGS_2)) v = {7'h00, s.periph_irq_flags_2};
    if (hit(a, A_OPTION)) v = s.option;
    if (hit(a, A_TRISA)) v = s.trisa;
    if (hit(a, A_PIE1)) v = s.pie1;
    if (hit(a, A_PIE2)) v = {7'h00, s.pie2};
    if (hit(a, A_RESET_CAUSE_FLAGS)) v = {6'h00, s.reset_cause_flags};
    if (hit(a, A_EVT)) v = {1'b0, s.evt};
    if (hit(a, A_EMASK)) v = {1'b0, s.mask};
    return v;
  endfunction

  // Filters the asynchronous reset pin.
  rsi_pin_sync u_pin_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .pin_in(ext_rst_pin_n_in),
    .level_out(pin_n_sync)
  );

  // Decodes the causes in priority order: brown-out, pin, watchdog, interrupt.
  always_comb begin
    pin_fall = s_q.pin_q & ~pin_n_sync;
    ev_bor = bor_in;
    ev_pin = ~ev_bor & pin_fall;
    ev_wdt = ~ev_bor & ~pin_fall & wdt_timeout_in;
    pend = (|(s_q.irq_control_reg[2:0] & s_q.irq_control_reg[5:3]))
         | (s_q.irq_control_reg[IC_PEIE] & ((|(s_q.periph_irq_flags_1 & s_q.pie1)) | (s_q.periph_irq_flags_2 & s_q.pie2)));
    ev_wake = ~ev_bor & ~pin_fall & ~wdt_timeout_in & (s_q.mode == RSI_SLEEP) & pend;
    wake_done = (s_q.mode == RSI_WAKE) & instr_done_in;
    ev_vec = ~ev_bor & ~pin_fall & ~wdt_timeout_in
           & (((s_q.mode == RSI_RUN) & s_q.irq_control_reg[IC_GIE] & pend) | (wake_done & s_q.gw));
  end

  // Next-state logic: bus access, flag capture, then the cause actions.
  always_comb begin
    s_d = s_q;
    s_d.pc_ld = 1'b0;
    s_d.pin_q = pin_n_sync;
    // Software writes; the timeout and powerdown bits are read-only.
    if (bus_in.wr) begin
      if (hit(bus_in.addr, A_STATUS)) begin
        s_d.status = {bus_in.wdata[7:5], s_q.status[4:3], bus_in.wdata[2:0]};
      end
      if (hit(bus_in.addr, A_IRQ_CONTROL_REG)) s_d.irq_control_reg = bus_in.wdata;
      if (hit(bus_in.addr, A_PERIPH_IRQ_FLAGS_1)) s_d.periph_irq_flags_1 = bus_in.wdata;
      if (hit(bus_in.addr, A_PERIPH_IRQ_FLAGS_2)) s_d.periph_irq_flags_2 = bus_in.wdata[0];
      if (hit(bus_in.addr, A_OPTION)) s_d.option = bus_in.wdata;
      if (hit(bus_in.addr, A_TRISA)) s_d.trisa = bus_in.wdata;
      if (hit(bus_in.addr, A_PIE1)) s_d.pie1 = bus_in.wdata;
      if (hit(bus_in.addr, A_PIE2)) s_d.pie2 = bus_in.wdata[0];
      if (hit(bus_in.addr, A_RESET_CAUSE_FLAGS)) s_d.reset_cause_flags = bus_in.wdata[1:0];
      if (hit(bus_in.addr, A_EMASK)) s_d.mask = bus_in.wdata[EVW-1:0];
    end
    // Each source sets its own flag; a set beats a clearing write.
    // per-source flags
    s_d.irq_control_reg[2:0] = s_d.irq_control_reg[2:0] | irq_src_in[2:0];
    s_d.periph_irq_flags_1 = s_d.periph_irq_flags_1 | irq_src_in[10:3];
    s_d.periph_irq_flags_2 = s_d.periph_irq_flags_2 | irq_src_in[11];
    // Reads capture data; a read of the event status register clears it.
    if (bus_in.rd) begin
      s_d.rdata = rd_mux(s_q, bus_in.addr);
      if (hit(bus_in.addr, A_EVT)) s_d.evt = '0;
    end
    // New events are sticky and win over the read clear.
    s_d.evt[EV_BOR] = s_d.evt[EV_BOR] | ev_bor;
    s_d.evt[EV_PIN] = s_d.evt[EV_PIN] | ev_pin;
    s_d.evt[EV_WDR] = s_d.evt[EV_WDR] | (ev_wdt & (s_q.mode != RSI_SLEEP));
    s_d.evt[EV_WDW] = s_d.evt[EV_WDW] | (ev_wdt & (s_q.mode == RSI_SLEEP));
    s_d.evt[EV_IWK] = s_d.evt[EV_IWK] | ev_wake;
    s_d.evt[EV_VEC] = s_d.evt[EV_VEC] | ev_vec;
    // Cause actions, highest priority first.
    if (ev_bor) begin
      s_d = ctrl_reset(s_d);
      s_d.status = {3'h0, 1'b1, 1'b1, s_q.status[2:0]};
      s_d.reset_cause_flags = RESET_CAUSE_FLAGS_BOR;
    end else if (ev_pin) begin
      s_d = ctrl_reset(s_d);
      s_d.reset_cause_flags = s_q.reset_cause_flags;
      if (s_q.mode == RSI_RUN) begin
        s_d.status = {3'h0, s_q.status[4:0]};
      end else begin
        s_d.status = {3'h0, 1'b1, 1'b0, s_q.status[2:0]};
      end
    end else if (ev_wdt) begin
      if (s_q.mode == RSI_SLEEP) begin
        s_d.status[ST_TO] = 1'b0;
        s_d.status[ST_PD] = 1'b0;
        s_d.pc = PCW'(pc_in + 1'b1);
        s_d.pc_ld = 1'b1;
        s_d.mode = RSI_RUN;
      end else begin
        s_d = ctrl_reset(s_d);
        s_d.reset_cause_flags = s_q.reset_cause_flags;
        s_d.status = {3'h0, 1'b0, s_q.status[3:0]};
      end
    end else if (ev_wake) begin
      s_d.status[ST_TO] = 1'b1;
      s_d.status[ST_PD] = 1'b0;
      s_d.pc = PCW'(pc_in + 1'b1);
      s_d.pc_ld = 1'b1;
      s_d.mode = RSI_WAKE;
      s_d.gw = s_q.irq_control_reg[IC_GIE];
    end else if (ev_vec) begin
      s_d.pc = PC_VECTOR;
      s_d.pc_ld = 1'b1;
      s_d.irq_control_reg[IC_GIE] = 1'b0;
      s_d.mode = RSI_RUN;
    end else if (wake_done) begin
      // The wake instruction retired with interrupts off; carry on.
      s_d.mode = RSI_RUN;
    end else if (sleep_in && (s_q.mode == RSI_RUN)) begin
      // Entering sleep sets timeout and clears powerdown.
      s_d.status[ST_TO] = 1'b1;
      s_d.status[ST_PD] = 1'b0;
      s_d.mode = RSI_SLEEP;
    end
  end

  // Registers the state; power-on loads the documented constants.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_q <= S_POR;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come from flip-flops except the level interrupt and the sleep flag, which are decoded from them.
  assign rdata_out = s_q.rdata;
  assign pc_load_out = s_q.pc_ld;
  assign pc_value_out = s_q.pc;
  assign status_out = s_q.status;
  assign reset_cause_out = s_q.reset_cause_flags;
  assign option_out = s_q.option;
  assign trisa_out = s_q.trisa;
  assign asleep_out = (s_q.mode == RSI_SLEEP);
  assign irq_out = |(s_q.evt & s_q.mask);

  // Power-on leaves PC zero, timeout and powerdown set, power-on flag clear.
  property p_por;
    @(posedge clk_in) !nrst_in |=> (pc_value_out == PC_RESET) && pc_load_out
      && (status_out[7:3] == 5'h03) && (reset_cause_out[PF_POR] == 1'b0);
  endproperty
  a_por: assert property (p_por) else $error("power-on state wrong");

  // Brown-out gives flags 10 and the power-up status pattern.
  property p_bor;
    @(posedge clk_in) disable iff (!nrst_in)
      ev_bor |=> (reset_cause_out == RESET_CAUSE_FLAGS_BOR) && (status_out[7:3] == 5'h03);
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out flags wrong");

  // Pin reset while running keeps timeout and powerdown.
  property p_pin_run;
    @(posedge clk_in) disable iff (!nrst_in)
      ev_pin && (s_q.mode == RSI_RUN) |=> (status_out[7:5] == 3'h0)
      && (status_out[4:0] == $past(status_out[4:0])) && (pc_value_out == PC_RESET);
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("pin reset status wrong");

  // Pin reset while asleep sets timeout and clears powerdown.
  property p_pin_slp;
    @(posedge clk_in) disable iff (!nrst_in)
      ev_pin && (s_q.mode == RSI_SLEEP) |=> (status_out[7:3] == 5'h02)
      && (reset_cause_out == $past(reset_cause_out));
  endproperty
  a_pin_slp: assert property (p_pin_slp) else $error("pin sleep reset wrong");

  // Watchdog reset clears timeout and keeps powerdown.
  property p_wdr;
    @(posedge clk_in) disable iff (!nrst_in)
      ev_wdt && (s_q.mode != RSI_SLEEP) |=> !status_out[ST_TO]
      && (status_out[ST_PD] == $past(status_out[ST_PD])) && pc_load_out;
  endproperty
  a_wdr: assert property (p_wdr) else $error("watchdog reset wrong");

  // Interrupt wake resumes at the next address with timeout set.
  property p_iwk;
    @(posedge clk_in) disable iff (!nrst_in)
      ev_wake |=> (pc_value_out == PCW'($past(pc_in) + 1'b1))
      && status_out[ST_TO] && !status_out[ST_PD] && pc_load_out;
  endproperty
  a_iwk: assert property (p_iwk) else $error("interrupt wake wrong");

  // With the global enable set, the vector follows the retired step.
  property p_vec;
    @(posedge clk_in) disable iff (!nrst_in)
      wake_done && s_q.gw && !ev_bor && !pin_fall && !wdt_timeout_in
      |=> (pc_value_out == PC_VECTOR) && !s_q.irq_control_reg[IC_GIE];
  endproperty
  a_vec: assert property (p_vec) else $error("vector load missing");

  // A pin reset restores option and direction to ones.
  property p_ctrl;
    @(posedge clk_in) disable iff (!nrst_in)
      ev_pin |=> (option_out == RST_ONES) && (trisa_out == RST_ONES) && (s_q.pie1 == RST_ZERO);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control defaults wrong");

  // Reset-cause flag reads show zero in the unimplemented bits.
  property p_unimp;
    @(posedge clk_in) disable iff (!nrst_in)
      bus_in.rd && hit(bus_in.addr, A_RESET_CAUSE_FLAGS) |=> (rdata_out[7:2] == 6'h00);
  endproperty
  a_unimp: assert property (p_unimp) else $error("unused bits not zero");

endmodule // rsi_core

//--- sim/rsi_core_model.sv
// Purpose: Behavioural processor core on the far side of the reset state initializer.
// Assumes: Program counter loads arrive as one-cycle pulses.
// Notes: It retires the resumed instruction two cycles after every load.
module rsi_core_model import rsi_pkg::*; (
  input wire logic clk_in,
  input wire logic pc_load_in,
  input wire logic [PCW-1:0] pc_value_in,
  output logic [PCW-1:0] pc_out,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Delay line of pending retire events, one stage a cycle.
  logic [1:0] dly_q = 2'h0;

  // The core holds its counter until the sequencer loads a new one.
  initial pc_out = 13'h0000;

  // Jump on each load and retire the resumed instruction a little later.
  always @(posedge clk_in) begin
    if (pc_load_in === 1'b1) begin
      pc_out <= pc_value_in;
    end
    dly_q <= {dly_q[0], pc_load_in === 1'b1};
  end

  // The retire pulse lasts exactly one cycle.
  assign done_out = dly_q[1];
endmodule // rsi_core_model

//--- sim/rsi_core_tb_top.sv
// Purpose: Self-checking bench for the reset and wake sequencer.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Low status bits after a power-up reset are unknown and left unchecked.
module rsi_core_tb_top import rsi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus driven by the bench.
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic bor = 1'b0;
  logic wdt = 1'b0;
  logic slp = 1'b0;
  logic pin_n = 1'b1;
  logic [NSRC-1:0] irq = '0;
  rsi_bus_t bus = '0;
  // Signals between the sequencer and the core model.
  logic [PCW-1:0] pc;
  logic done;
  logic pc_load_out;
  logic [PCW-1:0] pc_value_out;
  logic [DW-1:0] rdata_out;
  logic [DW-1:0] status_out;
  logic [1:0] reset_cause_out;
  logic [DW-1:0] option_out;
  logic [DW-1:0] trisa_out;
  logic asleep_out;
  logic irq_out;
  // Bookkeeping.
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // The sequencer under test.
  rsi_core u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .bor_in(bor),
    .ext_rst_pin_n_in(pin_n), .wdt_timeout_in(wdt), .sleep_in(slp),
    .instr_done_in(done), .pc_in(pc), .irq_src_in(irq), .bus_in(bus),
    .rdata_out(rdata_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
    .status_out(status_out), .reset_cause_out(reset_cause_out),
    .option_out(option_out), .trisa_out(trisa_out), .asleep_out(asleep_out),
    .irq_out(irq_out));

  // The processor core that follows the loads.
  rsi_core_model u_core (.clk_in(clk_in), .pc_load_in(pc_load_out),
    .pc_value_in(pc_value_out), .pc_out(pc), .done_out(done));

  // Clock of 4 ns period.
  always #2 clk_in = ~clk_in;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    n_compared++;
    if (got !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus <= '0;
  endtask

  // One-cycle register read; the data stand from the following cycle until the next read.
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    bus <= '0;
    #1;
    chk($sformatf("rdata at %h", a), e, rdata_out);
  endtask

  // One-cycle pulse of sleep, watchdog, brown-out and source events.
  task automatic pulse(input logic [2:0] e, input logic [NSRC-1:0] s);
    @(posedge clk_in);
    {slp, wdt, bor} <= e;
    irq <= s;
    @(posedge clk_in);
    {slp, wdt, bor} <= 3'h0;
    irq <= '0;
    #1;
  endtask

  // Waits a bounded time for a counter load and checks its target.
  task automatic wait_load(input logic [PCW-1:0] e);
    for (int i = 0; i < 12 && pc_load_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk("pc_load", 1'b1, pc_load_out);
    chk("pc_value", e, pc_value_out);
    @(posedge clk_in);
    #1;
  endtask

  // Drives the reset pin low until the load shows, then releases it.
  task automatic pin_reset();
    @(posedge clk_in);
    pin_n <= 1'b0;
    wait_load(PC_RESET);
    @(posedge clk_in);
    pin_n <= 1'b1;
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short after a generous ceiling.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  // Main sequence of reset and wake scenarios.
  initial begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    // Power-on values.
    chk("pc", PC_RESET, pc_value_out);
    chk("status_hi", 5'b00011, status_out[7:3]);
    chk("por_flag", 1'b0, reset_cause_out[PF_POR]);
    chk("option", RST_ONES, option_out);
    chk("trisa", RST_ONES, trisa_out);
    rd(A_PIE1, RST_ZERO);
    rd(A_PERIPH_IRQ_FLAGS_2, 8'h00);
    rd(9'h050, 8'h00);
    rd(A_EVT, 8'h01);
    // Software acknowledges power-on; protected status bits refuse writes.
    wr(A_RESET_CAUSE_FLAGS, 8'h03);
    wr(A_OPTION, 8'h55);
    wr(A_TRISA, 8'hAA);
    wr(A_STATUS, 8'hE5);
    rd(A_RESET_CAUSE_FLAGS, 8'h03);
    chk("status", 8'hFD, status_out);
    // Watchdog reset while running.
    pulse(3'b010, '0);
    wait_load(PC_RESET);
    chk("status", 8'h0D, status_out);
    chk("cause", 2'h3, reset_cause_out);
    chk("option", RST_ONES, option_out);
    chk("trisa", RST_ONES, trisa_out);
    // Pin reset while running.
    wr(A_STATUS, 8'hE5);
    wr(A_OPTION, 8'h55);
    pin_reset();
    chk("status", 8'h0D, status_out);
    chk("cause", 2'h3, reset_cause_out);
    chk("option", RST_ONES, option_out);
    rd(A_EVT, 8'h0C);
    // Pin reset while asleep.
    pulse(3'b100, '0);
    chk("asleep", 1'b1, asleep_out);
    wr(A_STATUS, 8'hE5);
    pin_reset();
    chk("status", 8'h15, status_out);
    chk("cause", 2'h3, reset_cause_out);
    chk("asleep", 1'b0, asleep_out);
    // Brown-out reset.
    wr(A_OPTION, 8'h55);
    pulse(3'b001, '0);
    wait_load(PC_RESET);
    chk("status_hi", 5'b00011, status_out[7:3]);
    chk("cause", RESET_CAUSE_FLAGS_BOR, reset_cause_out);
    chk("option", RST_ONES, option_out);
    rd(A_EVT, 8'h06);
    // Watchdog wake-up keeps the control registers.
    wr(A_RESET_CAUSE_FLAGS, 8'h03);
    wr(A_STATUS, 8'h05);
    wr(A_OPTION, 8'h55);
    pulse(3'b100, '0);
    pulse(3'b010, '0);
    wait_load(13'h0001);
    chk("status", 8'h05, status_out);
    chk("option", 8'h55, option_out);
    chk("cause", 2'h3, reset_cause_out);
    // Interrupt wake with the global enable set, masked event reaching the line.
    wr(A_IRQ_CONTROL_REG, 8'h88);
    wr(A_EMASK, 8'h20);
    rd(A_EVT, 8'h10);
    pulse(3'b100, '0);
    pulse(3'b000, 12'h001);
    wait_load(13'h0002);
    chk("status", 8'h15, status_out);
    chk("irq", 1'b1, irq_out);
    wait_load(PC_VECTOR);
    rd(A_IRQ_CONTROL_REG, 8'h09);
    rd(A_EVT, 8'h60);
    chk("irq", 1'b0, irq_out);
    // Peripheral source wakes without the global enable: no vector follows.
    wr(A_IRQ_CONTROL_REG, 8'h40);
    wr(A_PIE1, 8'h01);
    pulse(3'b100, '0);
    pulse(3'b000, 12'h008);
    wait_load(13'h0005);
    repeat (6) @(posedge clk_in);
    #1;
    chk("pc", 13'h0005, pc);
    rd(A_PERIPH_IRQ_FLAGS_1, 8'h01);
    rd(A_RESET_CAUSE_FLAGS, 8'h03);
    summarize();
  end
endmodule // rsi_core_tb_top
